// *** design/amp_i2c_control_status_regs.sv ***
/*
 * Register bank of a four-channel amplifier behind a two-wire serial slave port.
 * Assumes SCL/SDA/select/standby come from outside and are resynchronised here;
 * fault and live status inputs come from logic on MCLK.
 */
// What this block does
// [RULE1] answer write address 0xD8/DA/DC/DE by select pin; read address one higher
// [RULE2] status at 0x00-0x07 and 0x13, control 0x08-0x0D and 0x10, 0x0E-0x0F unused
// [RULE3] 0x00 latches global faults: warning, dc, overcurrent, shutdown, supplies
// [RULE4] 0x01 latches overcurrent in low nibble, dc offset in high nibble
// [RULE5] 0x02 and 0x03 latch load diagnostic nibbles, lower channel in low nibble
// [RULE6] 0x04 shows live supply, charge pump and shutdown faults
// [RULE7] 0x04 bit 5 shows warning present, bits 7:6 its level
// [RULE8] 0x05 gives high-impedance and low-low flags, reset all high-impedance
// [RULE9] a low-low channel drives both bridge outputs to ground
// [RULE10] 0x06 flags play in low nibble, mute in high nibble
// [RULE11] 0x07 flags diagnostics running and thermal foldback per channel
// [RULE12] 0x08 holds two-bit gain per channel, default 26 dB
// [RULE13] 0x09 holds current limit per channel and foldback disable bit
// [RULE14] 0x0A bits 1:0 select switching frequency; master never writes code 3
// [RULE15] 0x0A bits 3:2 select what the flag pin reports
// [RULE16] 0x0A hard stop, phase, sync pulse and foldback report bits
// [RULE17] standby low clears all registers and releases the bus
// [RULE18] register address advances after every data byte written and every acknowledged byte read
// [RULE19] unused addresses read zero and ignore writes
`timescale 1ns/1ps

module amp_i2c_control_status_regs (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic [1:0] ADDR_SEL,
   input wire logic STANDBY_N,
   input wire amp_regs_pkg::fault_evt_t FAULT_EVT,
   input wire amp_regs_pkg::live_stat_t LIVE,
   output amp_regs_pkg::ctl_out_t CTRL,
   output logic CLIP_FLAG_OUT,
   output logic CLIP_FLAG_OE,
   output logic OSCILLATOR_SYNC_PIN_PULSE
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic [4:0] s3_q;
   logic [4:0] pin_q;
   logic [4:0] pin_d;
   logic [4:0] pin_raw;

   assign pin_raw = {STANDBY_N, ADDR_SEL, SDA_IN, SCL_IN};
   // a bit changes only once the last two stages agree
   assign pin_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & pin_q);

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         s1_q <= amp_regs_pkg::PIN_RST;
         s2_q <= amp_regs_pkg::PIN_RST;
         s3_q <= amp_regs_pkg::PIN_RST;
         pin_q <= amp_regs_pkg::PIN_RST;
      end
      else if (CE)
      begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   logic scl;
   logic sda;
   logic [1:0] sel;
   logic clr;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl = pin_q[0];
   assign sda = pin_q[1];
   assign sel = pin_q[3:2];
   // [RULE17] standby clears everything
   assign clr = ~pin_q[4];

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else if (CE)
      begin
         scl_prev_q <= scl;
         sda_prev_q <= sda;
      end
   end

   assign scl_rise = scl & ~scl_prev_q;
   assign scl_fall = ~scl & scl_prev_q;
   assign bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
   assign bus_stop = scl & scl_prev_q & ~sda_prev_q & sda;

   // ------------------------------------------------------------
   // serial slave state machine
   // ------------------------------------------------------------
   amp_regs_pkg::bus_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic rw_q;
   logic have_sub_q;
   logic nack_q;
   logic [7:0] ptr_q;
   logic addr_match;
   logic rx_done;
   logic wr_stb;
   logic rd_first;
   logic rd_next;
   logic rd_take;
   logic [7:0] rd_addr;
   logic [7:0] rd_byte;

   // [RULE1] upper five bits fixed, low two from select pin
   assign addr_match = (sh_q[7:1] == {amp_regs_pkg::DEV_ADDR_HI, sel});
   assign rx_done = (state_q == amp_regs_pkg::ST_RX) && scl_fall && (cnt_q == 4'h8);
   assign wr_stb = rx_done && have_sub_q;
   assign rd_first = (state_q == amp_regs_pkg::ST_AACK) && scl_fall && rw_q;
   assign rd_next = (state_q == amp_regs_pkg::ST_TXACK) && scl_fall && !nack_q;
   assign rd_take = rd_first || rd_next;
   // [RULE18] next read byte comes from the following address
   assign rd_addr = rd_next ? ptr_q + 8'h01 : ptr_q;

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_q <= amp_regs_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         have_sub_q <= 1'b0;
         nack_q <= 1'b0;
      end
      else if (CE)
      begin
         if (clr || bus_stop)
         begin
            state_q <= amp_regs_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            have_sub_q <= 1'b0;
         end
         else if (bus_start)
         begin
            state_q <= amp_regs_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            have_sub_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               amp_regs_pkg::ST_ADDR, amp_regs_pkg::ST_RX:
               begin
                  if (scl_rise)
                  begin
                     sh_q <= {sh_q[6:0], sda};
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == 4'h8)
                  begin
                     cnt_q <= 4'h0;
                     if (state_q == amp_regs_pkg::ST_RX)
                     begin
                        state_q <= amp_regs_pkg::ST_RXACK;
                        have_sub_q <= 1'b1;
                     end
                     else if (addr_match)
                     begin
                        state_q <= amp_regs_pkg::ST_AACK;
                        rw_q <= sh_q[0];
                     end
                     else
                        state_q <= amp_regs_pkg::ST_IDLE;
                  end
               end
               amp_regs_pkg::ST_AACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     if (rw_q)
                     begin
                        state_q <= amp_regs_pkg::ST_TX;
                        sh_q <= rd_byte;
                     end
                     else
                        state_q <= amp_regs_pkg::ST_RX;
                  end
               end
               amp_regs_pkg::ST_RXACK:
               begin
                  if (scl_fall)
                     state_q <= amp_regs_pkg::ST_RX;
               end
               amp_regs_pkg::ST_TX:
               begin
                  if (scl_rise)
                     cnt_q <= cnt_q + 4'h1;
                  else if (scl_fall)
                  begin
                     if (cnt_q == 4'h8)
                        state_q <= amp_regs_pkg::ST_TXACK;
                     else
                        sh_q <= {sh_q[6:0], 1'b0};
                  end
               end
               amp_regs_pkg::ST_TXACK:
               begin
                  if (scl_rise)
                     nack_q <= sda;
                  else if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     if (nack_q)
                        state_q <= amp_regs_pkg::ST_IDLE;
                     else
                     begin
                        state_q <= amp_regs_pkg::ST_TX;
                        sh_q <= rd_byte;
                     end
                  end
               end
               default:
                  state_q <= amp_regs_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // [RULE18] sub-address loads from first byte, then steps per written or acknowledged read byte
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
         ptr_q <= 8'h00;
      else if (CE)
      begin
         if (clr)
            ptr_q <= 8'h00;
         else if (rx_done && !have_sub_q)
            ptr_q <= sh_q;
         else if (wr_stb || rd_next)
            ptr_q <= ptr_q + 8'h01;
      end
   end

   // ack slots and low data bits pull the line; released in standby
   assign SDA_OUT = 1'b0;
   assign SDA_OE = ~clr && ((state_q == amp_regs_pkg::ST_AACK)
                   || (state_q == amp_regs_pkg::ST_RXACK)
                   || ((state_q == amp_regs_pkg::ST_TX) && !sh_q[7]));

   // ------------------------------------------------------------
   // latched fault registers, cleared by reading them
   // ------------------------------------------------------------
   logic [7:0] glb_flt_q;
   logic [7:0] ch_flt_q;
   logic [7:0] diag12_q;
   logic [7:0] diag34_q;
   logic [7:0] glb_set;

   // [RULE3] any-channel flags are the or of the per-channel events
   assign glb_set = {FAULT_EVT.power_stage_supply_ov, FAULT_EVT.power_stage_supply_uv,
                     FAULT_EVT.analog_supply_uv, FAULT_EVT.cp_uv,
                     FAULT_EVT.thermal_shutdown, |FAULT_EVT.oc_ch,
                     |FAULT_EVT.dc_ch, FAULT_EVT.thermal_warning};

   function automatic logic [7:0] rd_clr(input logic take, input logic [7:0] a,
                                          input logic [7:0] off);
      rd_clr = (take && a == off) ? 8'hff : 8'h00;
   endfunction : rd_clr

   // set wins over a read in the same cycle
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         glb_flt_q <= amp_regs_pkg::RST_ZERO;
         ch_flt_q <= amp_regs_pkg::RST_ZERO;
         diag12_q <= amp_regs_pkg::RST_ZERO;
         diag34_q <= amp_regs_pkg::RST_ZERO;
      end
      else if (CE)
      begin
         if (clr)
         begin
            glb_flt_q <= amp_regs_pkg::RST_ZERO;
            ch_flt_q <= amp_regs_pkg::RST_ZERO;
            diag12_q <= amp_regs_pkg::RST_ZERO;
            diag34_q <= amp_regs_pkg::RST_ZERO;
         end
         else
         begin
            // [RULE3] global fault latch
            glb_flt_q <= (glb_flt_q & ~rd_clr(rd_take, rd_addr, amp_regs_pkg::OFF_GLB_FLT))
                         | glb_set;
            // [RULE4] overcurrent low nibble, dc offset high
            ch_flt_q <= (ch_flt_q & ~rd_clr(rd_take, rd_addr, amp_regs_pkg::OFF_CH_FLT))
                        | {FAULT_EVT.dc_ch, FAULT_EVT.oc_ch};
            // [RULE5] one nibble per channel, lower channel low
            diag12_q <= (diag12_q & ~rd_clr(rd_take, rd_addr, amp_regs_pkg::OFF_DIAG12))
                        | FAULT_EVT.load_diag[7:0];
            diag34_q <= (diag34_q & ~rd_clr(rd_take, rd_addr, amp_regs_pkg::OFF_DIAG34))
                        | FAULT_EVT.load_diag[15:8];
         end
      end
   end

   // ------------------------------------------------------------
   // live status registers
   // ------------------------------------------------------------
   logic [7:0] live_q;
   logic [7:0] outst_q;
   logic [7:0] playmute_q;
   logic [7:0] diagfb_q;
   logic [7:0] tsdfb_q;
   logic [7:0] outctl_b_q;

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         live_q <= amp_regs_pkg::RST_ZERO;
         outst_q <= amp_regs_pkg::RST_OUTST;
         playmute_q <= amp_regs_pkg::RST_ZERO;
         diagfb_q <= amp_regs_pkg::RST_ZERO;
         tsdfb_q <= amp_regs_pkg::RST_ZERO;
      end
      else if (CE)
      begin
         if (clr)
         begin
            live_q <= amp_regs_pkg::RST_ZERO;
            outst_q <= amp_regs_pkg::RST_OUTST;
            playmute_q <= amp_regs_pkg::RST_ZERO;
            diagfb_q <= amp_regs_pkg::RST_ZERO;
            tsdfb_q <= amp_regs_pkg::RST_ZERO;
         end
         else
         begin
            // [RULE6] [RULE7] present faults, warning flag and level
            live_q <= {LIVE.warn_level, |LIVE.warn_level, LIVE.thermal_shutdown,
                       LIVE.cp_fault, LIVE.analog_supply_fault,
                       LIVE.power_stage_supply_uv, LIVE.power_stage_supply_ov};
            // [RULE8] low-low follows its control bits
            outst_q <= {outctl_b_q[3:0], LIVE.hiz};
            // [RULE10] play low, mute high
            playmute_q <= {LIVE.mute, LIVE.play};
            // [RULE11] diagnostics low, foldback high
            diagfb_q <= {LIVE.foldback, LIVE.diag_run};
            tsdfb_q <= LIVE.tsd_foldback;
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [7:0] gain_q;
   logic [7:0] curlim_q;
   logic [7:0] freq_q;
   logic [7:0] diagsync_q;
   logic [7:0] outctl_a_q;
   logic [7:0] misc_q;

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         gain_q <= amp_regs_pkg::RST_GAIN;
         curlim_q <= amp_regs_pkg::RST_CURLIM;
         freq_q <= amp_regs_pkg::RST_FREQ;
         diagsync_q <= amp_regs_pkg::RST_DIAGSYNC;
         outctl_a_q <= amp_regs_pkg::RST_OUTCTL_A;
         outctl_b_q <= amp_regs_pkg::RST_OUTCTL_B;
         misc_q <= amp_regs_pkg::RST_MISC;
      end
      else if (CE)
      begin
         if (clr)
         begin
            gain_q <= amp_regs_pkg::RST_GAIN;
            curlim_q <= amp_regs_pkg::RST_CURLIM;
            freq_q <= amp_regs_pkg::RST_FREQ;
            diagsync_q <= amp_regs_pkg::RST_DIAGSYNC;
            outctl_a_q <= amp_regs_pkg::RST_OUTCTL_A;
            outctl_b_q <= amp_regs_pkg::RST_OUTCTL_B;
            misc_q <= amp_regs_pkg::RST_MISC;
         end
         else if (wr_stb)
         begin
            // [RULE2] [RULE19] only control offsets take writes
            case (ptr_q)
               // [RULE12] gain codes
               amp_regs_pkg::OFF_GAIN: gain_q <= sh_q;
               // [RULE13] limit and foldback disable
               amp_regs_pkg::OFF_CURLIM: curlim_q <= sh_q;
               // [RULE14] [RULE15] [RULE16] frequency, flag source, options
               amp_regs_pkg::OFF_FREQ: freq_q <= sh_q;
               amp_regs_pkg::OFF_DIAGSYNC: diagsync_q <= sh_q;
               amp_regs_pkg::OFF_OUTCTL_A: outctl_a_q <= sh_q;
               amp_regs_pkg::OFF_OUTCTL_B: outctl_b_q <= sh_q;
               amp_regs_pkg::OFF_MISC: misc_q <= sh_q;
               default: misc_q <= misc_q;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // read multiplexer
   // ------------------------------------------------------------
   always_comb
   begin
      // [RULE2] [RULE19] unmapped and unused addresses read zero
      case (rd_addr)
         amp_regs_pkg::OFF_GLB_FLT: rd_byte = glb_flt_q;
         amp_regs_pkg::OFF_CH_FLT: rd_byte = ch_flt_q;
         amp_regs_pkg::OFF_DIAG12: rd_byte = diag12_q;
         amp_regs_pkg::OFF_DIAG34: rd_byte = diag34_q;
         amp_regs_pkg::OFF_LIVE: rd_byte = live_q;
         amp_regs_pkg::OFF_OUTST: rd_byte = outst_q;
         amp_regs_pkg::OFF_PLAYMUTE: rd_byte = playmute_q;
         amp_regs_pkg::OFF_DIAGFB: rd_byte = diagfb_q;
         amp_regs_pkg::OFF_GAIN: rd_byte = gain_q;
         amp_regs_pkg::OFF_CURLIM: rd_byte = curlim_q;
         amp_regs_pkg::OFF_FREQ: rd_byte = freq_q;
         amp_regs_pkg::OFF_DIAGSYNC: rd_byte = diagsync_q;
         amp_regs_pkg::OFF_OUTCTL_A: rd_byte = outctl_a_q;
         amp_regs_pkg::OFF_OUTCTL_B: rd_byte = outctl_b_q;
         amp_regs_pkg::OFF_MISC: rd_byte = misc_q;
         amp_regs_pkg::OFF_TSD_FB: rd_byte = tsdfb_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // control outputs, flag pin and sync pulse
   // ------------------------------------------------------------
   assign CTRL.gain = gain_q;
   assign CTRL.cur_limit = curlim_q[amp_regs_pkg::CURLIM_LSB +: 4];
   assign CTRL.foldback_off = curlim_q[amp_regs_pkg::FB_DIS_BIT];
   assign CTRL.freq_sel = freq_q[amp_regs_pkg::FREQ_LSB +: 2];
   assign CTRL.hard_stop = freq_q[amp_regs_pkg::HARD_STOP_BIT];
   assign CTRL.phase_180 = freq_q[amp_regs_pkg::PHASE_BIT];
   assign CTRL.diag_sync = diagsync_q;
   assign CTRL.out_ctl_a = outctl_a_q;
   assign CTRL.out_ctl_b = outctl_b_q;
   assign CTRL.misc = misc_q;
   // [RULE9] low-low channels pull both bridge outputs to ground
   assign CTRL.bridge_low = outst_q[7:4];

   logic flag_src;
   logic warn;
   logic is_primary;

   assign warn = |LIVE.warn_level;
   // [RULE15] flag pin source select
   always_comb
   begin
      case (freq_q[amp_regs_pkg::FLAG_SEL_LSB +: 2])
         amp_regs_pkg::FLAG_TWEETER: flag_src = LIVE.tweeter;
         amp_regs_pkg::FLAG_CLIP: flag_src = LIVE.clip;
         amp_regs_pkg::FLAG_WARN: flag_src = warn;
         default: flag_src = LIVE.clip | warn;
      endcase
   end

   // [RULE16] sync only from the primary oscillator end
   assign is_primary = (sel == 2'h0) && diagsync_q[amp_regs_pkg::PRIMARY_BIT];
   assign CLIP_FLAG_OUT = 1'b0;

   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         CLIP_FLAG_OE <= 1'b0;
         OSCILLATOR_SYNC_PIN_PULSE <= 1'b0;
      end
      else if (CE)
      begin
         // [RULE16] foldback optionally reported too
         CLIP_FLAG_OE <= ~clr && (flag_src
                         || (freq_q[amp_regs_pkg::FB_REPORT_BIT] && |LIVE.foldback));
         // [RULE16] one-cycle sync pulse on write
         OSCILLATOR_SYNC_PIN_PULSE <= ~clr && wr_stb && (ptr_q == amp_regs_pkg::OFF_FREQ)
                           && sh_q[amp_regs_pkg::SYNC_BIT] && is_primary;
      end
   end

endmodule : amp_i2c_control_status_regs

// *** design/amp_regs_pkg.sv ***
/*
 * Shared constants and types for the amplifier control/status register bank.
 * Assumes a single 20 MHz device clock; the serial bus runs far slower.
 */
package amp_regs_pkg;

   // serial bus slave address: upper five bits fixed, low two from the select pin
   localparam logic [4:0] DEV_ADDR_HI = 5'h1b;

   localparam logic [7:0] OFF_GLB_FLT = 8'h00;
   localparam logic [7:0] OFF_CH_FLT = 8'h01;
   localparam logic [7:0] OFF_DIAG12 = 8'h02;
   localparam logic [7:0] OFF_DIAG34 = 8'h03;
   localparam logic [7:0] OFF_LIVE = 8'h04;
   localparam logic [7:0] OFF_OUTST = 8'h05;
   localparam logic [7:0] OFF_PLAYMUTE = 8'h06;
   localparam logic [7:0] OFF_DIAGFB = 8'h07;
   localparam logic [7:0] OFF_GAIN = 8'h08;
   localparam logic [7:0] OFF_CURLIM = 8'h09;
   localparam logic [7:0] OFF_FREQ = 8'h0a;
   localparam logic [7:0] OFF_DIAGSYNC = 8'h0b;
   localparam logic [7:0] OFF_OUTCTL_A = 8'h0c;
   localparam logic [7:0] OFF_OUTCTL_B = 8'h0d;
   localparam logic [7:0] OFF_MISC = 8'h10;
   localparam logic [7:0] OFF_TSD_FB = 8'h13;

   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_OUTST = 8'h0f;
   localparam logic [7:0] RST_GAIN = 8'haa;
   localparam logic [7:0] RST_CURLIM = 8'hf0;
   localparam logic [7:0] RST_FREQ = 8'h0d;
   localparam logic [7:0] RST_DIAGSYNC = 8'h50;
   localparam logic [7:0] RST_OUTCTL_A = 8'h1f;
   localparam logic [7:0] RST_OUTCTL_B = 8'h00;
   localparam logic [7:0] RST_MISC = 8'h01;

   // fields of the frequency / flag-pin, current limit and diag/sync registers
   localparam int FREQ_LSB = 0;
   localparam int FLAG_SEL_LSB = 2;
   localparam int HARD_STOP_BIT = 4;
   localparam int PHASE_BIT = 5;
   localparam int SYNC_BIT = 6;
   localparam int FB_REPORT_BIT = 7;
   localparam int FB_DIS_BIT = 0;
   localparam int CURLIM_LSB = 4;
   localparam int PRIMARY_BIT = 6;

   localparam logic [1:0] FLAG_TWEETER = 2'h0;
   localparam logic [1:0] FLAG_CLIP = 2'h1;
   localparam logic [1:0] FLAG_WARN = 2'h2;
   localparam logic [1:0] FLAG_BOTH = 2'h3;

   // synchronised pin bundle {standby_n, addr_sel[1:0], sda, scl}
   localparam logic [4:0] PIN_RST = 5'h1f;

   typedef struct packed {
      logic thermal_warning;
      logic thermal_shutdown;
      logic cp_uv;
      logic analog_supply_uv;
      logic power_stage_supply_uv;
      logic power_stage_supply_ov;
      logic [3:0] oc_ch;
      logic [3:0] dc_ch;
      logic [15:0] load_diag;
   } fault_evt_t;

   typedef struct packed {
      logic power_stage_supply_ov;
      logic power_stage_supply_uv;
      logic analog_supply_fault;
      logic cp_fault;
      logic thermal_shutdown;
      logic [1:0] warn_level;
      logic [3:0] hiz;
      logic [3:0] play;
      logic [3:0] mute;
      logic [3:0] diag_run;
      logic [3:0] foldback;
      logic [7:0] tsd_foldback;
      logic clip;
      logic tweeter;
   } live_stat_t;

   typedef struct packed {
      logic [7:0] gain;
      logic [3:0] cur_limit;
      logic foldback_off;
      logic [1:0] freq_sel;
      logic hard_stop;
      logic phase_180;
      logic [7:0] diag_sync;
      logic [7:0] out_ctl_a;
      logic [7:0] out_ctl_b;
      logic [7:0] misc;
      logic [3:0] bridge_low;
   } ctl_out_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_RX = 7'h08,
      ST_RXACK = 7'h10,
      ST_TX = 7'h20,
      ST_TXACK = 7'h40
   } bus_state_t;

endpackage : amp_regs_pkg

// *** sim/amp_regs_sva.sv ***
/* port assertions for the register bank
   bound to the top module, one MCLK domain */
`timescale 1ns/1ps
module amp_regs_sva (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic SCL_IN,
   input wire logic STANDBY_N,
   input wire logic [1:0] ADDR_SEL,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic OSCILLATOR_SYNC_PIN_PULSE,
   input wire amp_regs_pkg::ctl_out_t CTRL
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!NRST);
   sequence s_stby;
      !STANDBY_N [*5];
   endsequence
   property p_rst;
      $rose(NRST) |-> CTRL.gain == 8'haa && CTRL.cur_limit == 4'hf && CTRL.freq_sel == 2'h1;
   endproperty
   property p_stby_sda;
      s_stby |-> !SDA_OE;
   endproperty
   property p_stby_ctl;
      s_stby ##1 !STANDBY_N |-> CTRL.gain == 8'haa && CTRL.out_ctl_b == 8'h00;
   endproperty
   property p_bridge;
      STANDBY_N && $past(STANDBY_N, 6) |-> CTRL.bridge_low == $past(CTRL.out_ctl_b[3:0]);
   endproperty
   property p_sync_pri;
      OSCILLATOR_SYNC_PIN_PULSE |-> ADDR_SEL == 2'h0 && CTRL.diag_sync[6];
   endproperty
   property p_sync_one;
      OSCILLATOR_SYNC_PIN_PULSE |=> !OSCILLATOR_SYNC_PIN_PULSE;
   endproperty
   property p_wr_fall;
      $changed(CTRL.gain) && STANDBY_N |-> !$past(SCL_IN, 2);
   endproperty
   property p_od;
      SDA_OUT == 1'b0;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   a_stby_sda: assert property (p_stby_sda) else $error("bus held");
   a_stby_ctl: assert property (p_stby_ctl) else $error("not cleared");
   a_bridge: assert property (p_bridge) else $error("bridge state");
   a_sync_pri: assert property (p_sync_pri) else $error("sync pulse");
   a_sync_one: assert property (p_sync_one) else $error("long pulse");
   a_wr_fall: assert property (p_wr_fall) else $error("write timing");
   a_od: assert property (p_od) else $error("data driven high");
endmodule : amp_regs_sva
bind amp_i2c_control_status_regs amp_regs_sva i_sva (.*);

// *** sim/amp_i2c_master.sv ***
/* two-wire bus master, 400 ns bit cell
   wire has a pull-up; slave pulls low */
`timescale 1ns/1ps
module amp_i2c_master (
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic low_q = 1'b0;
   initial scl = 1'b1;
   assign sda = !(sda_oe || low_q);
   task automatic bit_io(input logic b, output logic r);
      #100 low_q = !b;
      #150 scl = 1'b1;
      #75 r = sda;
      #75 scl = 1'b0;
   endtask : bit_io
   task automatic start();
      #113 low_q = 1'b0;
      #150 scl = 1'b1;
      #100 low_q = 1'b1;
      #100 scl = 1'b0;
   endtask : start
   task automatic stop();
      #100 low_q = 1'b1;
      #150 scl = 1'b1;
      #100 low_q = 1'b0;
      #200;
   endtask : stop
   task automatic xfer(input logic [7:0] t, input logic l, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(t[i], r[i]);
      bit_io(l, a);
   endtask : xfer
endmodule : amp_i2c_master

// *** sim/tb_amp_i2c_control_status_regs.sv ***
/* bench for the register bank
   bus traffic comes from amp_i2c_master */
`timescale 1ns/1ps
module tb_amp_i2c_control_status_regs;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic standby_n = 1'b1;
   logic [1:0] sel = 2'h0;
   amp_regs_pkg::fault_evt_t evt = '0;
   amp_regs_pkg::live_stat_t live = '0;
   amp_regs_pkg::ctl_out_t ctrl;
   logic scl;
   logic sda;
   logic sda_oe;
   logic flag_oe;
   logic sync_p;
   int pulses = 0;
   logic [7:0] rx;
   logic ak;
   int failures = 0;
   int checks = 0;
   always #25 mclk = !mclk;
   amp_i2c_master i_bus (.sda_oe(sda_oe), .scl(scl), .sda(sda));
   amp_i2c_control_status_regs i_dut (.MCLK(mclk), .NRST(nrst), .CE(1'b1), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .ADDR_SEL(sel), .STANDBY_N(standby_n),
      .FAULT_EVT(evt), .LIVE(live), .CTRL(ctrl), .CLIP_FLAG_OUT(), .CLIP_FLAG_OE(flag_oe),
      .OSCILLATOR_SYNC_PIN_PULSE(sync_p));
   always @(posedge mclk)
      if (sync_p === 1'b1)
         pulses <= pulses + 1;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic bx(input logic [7:0] t);
      i_bus.xfer(t, 1'b1, rx, ak);
      chk("ack", 8'h00, {7'h0, ak});
   endtask : bx
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_bus.start();
      bx({5'b11011, sel, 1'b0});
      bx(a);
      bx(d);
      i_bus.stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_bus.start();
      bx({5'b11011, sel, 1'b0});
      bx(a);
      i_bus.start();
      bx({5'b11011, sel, 1'b1});
      i_bus.xfer(8'hff, 1'b1, rx, ak);
      i_bus.stop();
      chk("reg", e, rx);
   endtask : rd
   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      live.hiz <= 4'hf;
      live.clip <= 1'b1;
      live.warn_level <= 2'h2;
      live.thermal_shutdown <= 1'b1;
      live.play <= 4'h3;
      live.mute <= 4'hc;
      live.diag_run <= 4'h1;
      live.foldback <= 4'h8;
      live.tsd_foldback <= 8'h5a;
      evt.thermal_warning <= 1'b1;
      evt.oc_ch <= 4'h4;
      evt.load_diag <= 16'h8421;
      @(posedge mclk);
      evt <= '0;
      repeat (8) @(posedge mclk);
      rd(8'h08, 8'haa);
      rd(8'h09, 8'hf0);
      rd(8'h0a, 8'h0d);
      rd(8'h05, 8'h0f);
      rd(8'h04, 8'hb0);
      rd(8'h00, 8'h05);
      rd(8'h01, 8'h04);
      rd(8'h02, 8'h21);
      rd(8'h03, 8'h84);
      rd(8'h06, 8'hc3);
      rd(8'h07, 8'h81);
      rd(8'h13, 8'h5a);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h0a, {4'h4, s[1:0], 2'h1});
         chk("flag", {7'h0, s != 0}, {7'h0, flag_oe});
      end
      chk("sync", 8'h04, pulses[7:0]);
      i_bus.start();
      bx(8'hd8);
      bx(8'h08);
      bx(8'h55);
      bx(8'h71);
      i_bus.stop();
      rd(8'h09, 8'h71);
      chk("gain", 8'h55, ctrl.gain);
      wr(8'h0d, 8'h05);
      chk("bridge", 8'h05, {4'h0, ctrl.bridge_low});
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'h00);
      @(posedge mclk);
      sel <= 2'h3;
      repeat (8) @(posedge mclk);
      rd(8'h08, 8'h55);
      i_bus.start();
      i_bus.xfer(8'hd8, 1'b1, rx, ak);
      i_bus.stop();
      chk("nack", 8'h01, {7'h0, ak});
      @(posedge mclk);
      standby_n <= 1'b0;
      repeat (10) @(posedge mclk);
      standby_n <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(8'h08, 8'haa);
      end_sim();
   end
   initial
   begin
      #2000000;
      failures++;
      end_sim();
   end
endmodule : tb_amp_i2c_control_status_regs
